// ===== src/hpc_pkg.sv
package hpc_pkg;

  // Halt-mode field encodings.
  localparam logic [1:0] MODE_SLEEP_OSC   = 2'h0;
  localparam logic [1:0] MODE_SLEEP_TIMER = 2'h1;
  localparam logic [1:0] MODE_STOP        = 2'h2;
  localparam logic [1:0] MODE_RUN         = 2'h3;
  localparam logic [1:0] MODE_RESET_VAL   = 2'h3;

  // Field position in the watchdog mode register.
  localparam int MODE_FIELD_LSB = 3;
  localparam int MODE_FIELD_MSB = 4;

  // Unlock value for the watchdog command register.
  localparam logic [7:0] UNLOCK_VALUE = 8'hDB;

  // Machine cycle: four T states, T1..T4.
  localparam logic [1:0] T_STATE_T4 = 2'h3;

  // Timing figures.
  localparam int CLOCK_PERIOD_NS   = 10;
  localparam int RESET_MIN_CYCLES  = 3;
  localparam int DUMMY_T_STATES    = 2;
  localparam int WARMUP_EXP        = 14;
  localparam int WARMUP_CYCLES     = (1 << WARMUP_EXP) + 3;
  localparam int WARMUP_WIDTH      = 15;
  localparam logic [15:0] FIRST_FETCH_ADDR = 16'h0000;

  typedef enum logic [2:0] {
    ST_RUN     = 3'b000,
    ST_HALTNOP = 3'b001,
    ST_GATED   = 3'b010,
    ST_WARMUP  = 3'b011,
    ST_RETRY   = 3'b100,
    ST_DUMMY   = 3'b101
  } hpc_state_t;

endpackage

// ===== src/hpc_sync.sv
`timescale 1ns/10ps
`default_nettype none
module hpc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             enable,
  input  wire logic [WIDTH-1:0] async,
  output var  logic [WIDTH-1:0] sync
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync;

  // Inactive pins are high, so reset loads ones.
  always_comb
  begin
    next_stage1 = async;
    next_sync   = stage1;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      stage1 <= '1;
      sync   <= '1;
    end
    else if (enable)
    begin
      stage1 <= next_stage1;
      sync   <= next_sync;
    end
  end

endmodule
`default_nettype wire

// ===== src/hpc_halt_clock_control.sv
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Two-bit halt-mode field picks power-down behaviour.
// - Mode only acts when halt executes.
// - Halt status goes low at T4.
// - Halted with clock running: repeat no-op cycles.
// - Mode 11: all clocks keep running.
// - Mode 00: oscillator runs, other clocks stop.
// - Mode 01: oscillator, clock output, timer run.
// - Mode 10: everything including oscillator stops.
// - Interrupts sampled at T4; maskable active low.
// - Stopped clock restarts on reset or interrupt.
// - Oscillator-only mode restarts clock output together.
// - After restart: one no-op, sample, then service.
// - No interrupt accepted: stop clocks again.
// - After reset: dummy states, fetch 0000H.
// - Full stop release by interrupt waits warm-up count; release by reset does not.
module hpc_halt_clock_control
#(
  parameter int WARMUP_COUNT = hpc_pkg::WARMUP_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        clockEnable,
  input  wire logic        haltFetch,
  input  wire logic        cmdWrite,
  input  wire logic [7:0]  cmdData,
  input  wire logic        modeWrite,
  input  wire logic [7:0]  modeData,
  input  wire logic        resetPin_n,
  input  wire logic        nmiPin_n,
  input  wire logic        intPin_n,
  input  wire logic        intEnable,
  output var  logic [1:0]  tState,
  output var  logic [1:0]  haltMode,
  output var  logic        haltStatus_n,
  output var  logic        oscillatorRun,
  output var  logic        clockOutputRun,
  output var  logic        processorClockRun,
  output var  logic        counterTimerClockRun,
  output var  logic        peripheralClockRun,
  output var  logic        cpuReset,
  output var  logic        nmiAccept,
  output var  logic        intAccept,
  output var  logic        fetchStart,
  output var  logic [15:0] fetchAddr
);
  import hpc_pkg::*;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [2:0] pinSync;
  logic       resetIn;
  logic       nmiIn;
  logic       intIn;

  hpc_sync #(
    .WIDTH (3)
  ) u_sync (
    .clock  (clock),
    .rst    (rst),
    .enable (clockEnable),
    .async  ({resetPin_n, nmiPin_n, intPin_n}),
    .sync   (pinSync)
  );

  assign resetIn = ~pinSync[2];
  assign nmiIn   = ~pinSync[1];
  assign intIn   = ~pinSync[0] & intEnable;

  // ****************************************************************
  // Mode field with unlock
  // ****************************************************************
  logic unlocked;
  logic next_unlocked;
  logic [1:0] next_haltMode;

  // A stray write without the unlock leaves the mode alone, so runaway
  // code cannot silence the watchdog by stopping its clock.
  always_comb
  begin
    next_unlocked = unlocked;
    next_haltMode = haltMode;
    if (cmdWrite)
    begin
      next_unlocked = (cmdData == UNLOCK_VALUE);
    end
    else if (modeWrite)
    begin
      next_unlocked = 1'b0;
      if (unlocked)
      begin
        next_haltMode = modeData[MODE_FIELD_MSB:MODE_FIELD_LSB];
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst || resetIn)
    begin
      unlocked <= 1'b0;
      haltMode <= MODE_RESET_VAL;
    end
    else if (clockEnable)
    begin
      unlocked <= next_unlocked;
      haltMode <= next_haltMode;
    end
  end

  // ****************************************************************
  // Halt state machine
  // ****************************************************************
  hpc_state_t state;
  hpc_state_t next_state;
  logic [1:0] next_tState;
  logic [WARMUP_WIDTH-1:0] count;
  logic [WARMUP_WIDTH-1:0] next_count;
  logic       next_haltStatus_n;
  logic       wakeReq;
  logic       atT4;
  logic       accept;

  assign wakeReq = nmiIn | intIn;
  assign atT4    = (tState == T_STATE_T4);
  // A frozen machine must not report an accept that it will not act on.
  assign accept  = clockEnable && atT4 && wakeReq
                   && (state == ST_HALTNOP || state == ST_RETRY);

  always_comb
  begin
    next_state        = state;
    next_tState       = tState + 2'h1;
    next_count        = count;
    next_haltStatus_n = haltStatus_n;
    unique case (state)
      ST_RUN:
      begin
        if (haltFetch && atT4)
        begin
          next_haltStatus_n = 1'b0;
          next_state = (haltMode == MODE_RUN) ? ST_HALTNOP : ST_GATED;
        end
      end
      ST_HALTNOP:
      begin
        if (accept)
        begin
          next_state        = ST_RUN;
          next_haltStatus_n = 1'b1;
        end
      end
      ST_GATED:
      begin
        next_tState = tState;
        if (wakeReq)
        begin
          if (haltMode == MODE_STOP)
          begin
            next_state = ST_WARMUP;
            next_count = '0;
          end
          else
          begin
            next_state  = ST_RETRY;
            next_tState = 2'h0;
          end
        end
      end
      ST_WARMUP:
      begin
        next_tState = tState;
        next_count  = count + 1'b1;
        if (count == WARMUP_WIDTH'(WARMUP_COUNT - 1))
        begin
          next_state  = ST_RETRY;
          next_tState = 2'h0;
        end
      end
      ST_RETRY:
      begin
        if (accept)
        begin
          next_state        = ST_RUN;
          next_haltStatus_n = 1'b1;
        end
        else if (atT4)
        begin
          next_state = ST_GATED;
        end
      end
      ST_DUMMY:
      begin
        next_count = count + 1'b1;
        if (count == WARMUP_WIDTH'(DUMMY_T_STATES - 1))
        begin
          next_state  = ST_RUN;
          next_tState = 2'h0;
        end
      end
      default:
      begin
        next_state = ST_RUN;
      end
    endcase
  end

  // Reset from any state restarts the clock at once and releases halt; the
  // oscillator gets no warm-up count then, so the pin must be held long.
  always_ff @(posedge clock)
  begin
    if (rst || resetIn)
    begin
      state        <= ST_DUMMY;
      tState       <= 2'h0;
      count        <= '0;
      haltStatus_n <= 1'b1;
    end
    else if (clockEnable)
    begin
      state        <= next_state;
      tState       <= next_tState;
      count        <= next_count;
      haltStatus_n <= next_haltStatus_n;
    end
  end

  // ****************************************************************
  // Clock gating outputs
  // ****************************************************************
  logic gated;
  logic stopped;

  assign gated   = (state == ST_GATED) || (state == ST_WARMUP);
  assign stopped = gated && (haltMode == MODE_STOP);

  always_comb
  begin
    oscillatorRun        = ~(state == ST_GATED && haltMode == MODE_STOP);
    processorClockRun    = ~gated;
    peripheralClockRun   = ~gated;
    clockOutputRun       = ~gated || (haltMode == MODE_SLEEP_TIMER);
    counterTimerClockRun = ~gated || (haltMode == MODE_SLEEP_TIMER);
    if (stopped)
    begin
      clockOutputRun       = 1'b0;
      counterTimerClockRun = 1'b0;
    end
  end

  // ****************************************************************
  // Interrupt acceptance and reset handoff
  // ****************************************************************
  always_comb
  begin
    cpuReset   = (state == ST_DUMMY);
    nmiAccept  = accept && nmiIn;
    intAccept  = accept && !nmiIn && intIn;
    fetchStart = (state == ST_DUMMY) && (count == WARMUP_WIDTH'(DUMMY_T_STATES - 1));
    fetchAddr  = FIRST_FETCH_ADDR;
  end

endmodule
`default_nettype wire

// ===== bench/hpc_halt_clock_control_props.sv
`timescale 1ns/10ps
`default_nettype none
module hpc_halt_clock_control_props
  import hpc_pkg::*;
#(
  parameter int WARMUP_COUNT = 8
) (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        haltFetch,
  input wire logic [1:0]  tState,
  input wire logic [1:0]  haltMode,
  input wire logic        haltStatus_n,
  input wire logic        oscillatorRun,
  input wire logic        clockOutputRun,
  input wire logic        counterTimerClockRun,
  input wire logic        peripheralClockRun,
  input wire logic        processorClockRun,
  input wire logic        cpuReset,
  input wire logic        intAccept,
  input wire logic        nmiAccept,
  input wire logic        fetchStart,
  input wire logic [15:0] fetchAddr
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  localparam int WMAX = WARMUP_COUNT + 8;
  wire logic h = !haltStatus_n;
  wire logic [4:0] g = {oscillatorRun, clockOutputRun, counterTimerClockRun,
                        peripheralClockRun, processorClockRun};
  // Cycles with the oscillator up and the processor clock still held off.
  logic [15:0] warmCount;
  always_ff @(posedge clock)
    warmCount <= (rst || processorClockRun || !oscillatorRun) ? 16'h0000 : warmCount + 16'h0001;
  a_warmup_len:
    assert property (h && haltMode == MODE_STOP && $rose(processorClockRun)
                     |-> warmCount == WARMUP_COUNT)
    else $error("warm-up count not exact");
  a_halt_entry:
    assert property ($fell(haltStatus_n) |-> $past(haltFetch) && $past(tState) == T_STATE_T4)
    else $error("halt status fell without a halt fetch at T4");
  a_run_keeps:
    assert property (h && haltMode == MODE_RUN |-> g == 5'h1F)
    else $error("clock stopped in run mode");
  a_osc_sleep:
    assert property (h && haltMode == MODE_SLEEP_OSC |-> oscillatorRun && g[3:0] == {4{g[0]}})
    else $error("oscillator-only sleep gating wrong");
  a_timer_sleep:
    assert property (h && haltMode == MODE_SLEEP_TIMER |-> g[4:2] == 3'h7 && g[1] == g[0])
    else $error("timer-keeping sleep gating wrong");
  a_stop_gate:
    assert property (h && haltMode == MODE_STOP && !processorClockRun |-> g[3:1] == 3'h0)
    else $error("clock running in full stop");
  a_warmup_wait:
    assert property (h && $rose(oscillatorRun) |-> !processorClockRun[*4] ##[1:WMAX] processorClockRun)
    else $error("warm-up length wrong");
  a_one_nop:
    assert property (h && $rose(processorClockRun) |-> tState == 2'h0 ##3 tState == T_STATE_T4
                     ##1 (haltStatus_n || !processorClockRun))
    else $error("restart cycle wrong");
  a_accept_t4:
    assert property (intAccept || nmiAccept |-> tState == T_STATE_T4 && processorClockRun)
    else $error("interrupt accepted outside T4");
  a_release:
    assert property (h && (intAccept || nmiAccept) |=> haltStatus_n && g == 5'h1F)
    else $error("halt not released after accept");
  a_first_fetch:
    assert property (fetchStart |-> cpuReset && $past(cpuReset) && fetchAddr == 16'h0000 ##1 !cpuReset)
    else $error("first fetch wrong");
endmodule
bind hpc_halt_clock_control hpc_halt_clock_control_props #(.WARMUP_COUNT(WARMUP_COUNT))
  chk_i (.*);
`default_nettype wire

// ===== bench/hpc_pin_source.sv
`timescale 1ns/10ps
`default_nettype none
module hpc_pin_source (
  input  wire logic clock,
  input  wire logic wantInt,
  input  wire logic wantNmi,
  input  wire logic wantReset,
  output var  logic intPin_n,
  output var  logic nmiPin_n,
  output var  logic resetPin_n
);
  logic [2:0] hold = 3'h0;
  // Pins have pull-ups, so a released source reads high.
  assign intPin_n = !wantInt;
  assign nmiPin_n = !wantNmi;
  // A short request is stretched by four cycles to cover the three-cycle reset minimum.
  always @(posedge clock)
    hold <= wantReset ? 3'h4 : hold - 3'(hold != 3'h0);
  assign resetPin_n = !(wantReset || hold != 3'h0);
endmodule
`default_nettype wire

// ===== bench/test_hpc_halt_clock_control.sv
`timescale 1ns/10ps
`default_nettype none
module test_hpc_halt_clock_control;
  import hpc_pkg::*;
  logic clock = 1'b0, rst = 1'b1, clockEnable = 1'b1, haltFetch = 1'b0, intEnable = 1'b0;
  logic cmdWrite = 1'b0, modeWrite = 1'b0, wantInt = 1'b0, wantNmi = 1'b0, wantReset = 1'b0;
  logic [7:0] cmdData = 8'h00, modeData = 8'h00;
  wire logic resetPin_n, nmiPin_n, intPin_n, haltStatus_n, cpuReset, nmiAccept, intAccept;
  wire logic oscillatorRun, clockOutputRun, counterTimerClockRun, peripheralClockRun;
  wire logic processorClockRun, fetchStart;
  wire logic [1:0] tState, haltMode;
  wire logic [15:0] fetchAddr;
  wire logic [4:0] clockRuns = {oscillatorRun, clockOutputRun, counterTimerClockRun,
                                peripheralClockRun, processorClockRun};
  int n_errors = 0, compares = 0;
  hpc_pin_source hpc_pin_source_i (.*);
  hpc_halt_clock_control #(.WARMUP_COUNT(8)) hpc_halt_clock_control_i (.*);
  // The bench clock plays a crystal-fed generator, so every halt mode is legal.
  always #5 clock = ~clock;
  // ****
  // Helpers
  // ****
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("compares %0d, errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic set_mode(input logic [7:0] cmd, input logic [1:0] m);
    cmdWrite = 1'b1;
    cmdData = cmd;
    step(1);
    cmdWrite = 1'b0;
    modeWrite = 1'b1;
    modeData = {3'h0, m, 3'h0};
    step(1);
    modeWrite = 1'b0;
    step(1);
  endtask
  task automatic enter_halt(input logic [1:0] m);
    logic [4:0] want [4] = '{5'h10, 5'h1C, 5'h00, 5'h1F};
    set_mode(UNLOCK_VALUE, m);
    chk(haltMode, m);
    chk(clockRuns, 5'h1F);
    for (int i = 0; i < 8 && tState !== T_STATE_T4; i++) step(1);
    haltFetch = 1'b1;
    step(1);
    haltFetch = 1'b0;
    chk(haltStatus_n, 1'b0);
    chk(clockRuns, want[m]);
  endtask
  // The wait covers synchronisers, warm-up and the retry cycle.
  task automatic wake(input bit nmi);
    int i;
    wantNmi = nmi;
    wantInt = !nmi;
    for (i = 0; i < 40 && (nmi ? nmiAccept : intAccept) !== 1'b1; i++) step(1);
    if (i == 40)
    begin
      n_errors++;
      $display("unexpected at %0t: no accept before the limit", $time);
      test_done();
    end
    chk(processorClockRun, 1'b1);
    step(1);
    wantNmi = 1'b0;
    wantInt = 1'b0;
    chk(haltStatus_n, 1'b1);
    chk(clockRuns, 5'h1F);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_unlock;
    chk(haltMode, MODE_RESET_VAL);
    set_mode(8'h5A, MODE_SLEEP_OSC);
    chk(haltMode, MODE_RESET_VAL);
  endtask
  task automatic t_modes;
    for (int m = 0; m < 4; m++)
    begin
      enter_halt(2'(m));
      wake(m == 2);
    end
  endtask
  task automatic t_masked;
    logic [1:0] held;
    intEnable = 1'b0;
    enter_halt(MODE_RUN);
    wantInt = 1'b1;
    step(12);
    chk(haltStatus_n, 1'b0);
    clockEnable = 1'b0;
    intEnable = 1'b1;
    held = tState;
    step(8);
    chk({haltStatus_n, intAccept, tState}, {2'b00, held});
    clockEnable = 1'b1;
    wake(1'b0);
  endtask
  task automatic t_retry;
    enter_halt(MODE_SLEEP_TIMER);
    wantInt = 1'b1;
    step(2);
    wantInt = 1'b0;
    step(12);
    chk({haltStatus_n, processorClockRun}, 2'h0);
    wake(1'b0);
  endtask
  task automatic t_reset;
    int i;
    enter_halt(MODE_STOP);
    wantReset = 1'b1;
    step(1);
    wantReset = 1'b0;
    for (i = 0; i < 30 && fetchStart !== 1'b1; i++) step(1);
    chk(i < 30, 1'b1);
    chk(fetchAddr, 16'h0000);
    step(1);
    chk({haltStatus_n, cpuReset}, 2'h2);
  endtask
  initial
  begin
    repeat (16) @(posedge clock);
    #1;
    rst = 1'b0;
    step(4);
    intEnable = 1'b1;
    t_unlock();
    t_modes();
    t_masked();
    t_retry();
    t_reset();
    test_done();
  end
endmodule
`default_nettype wire
